// File: hw/reader_timer_unit.v
// timer unit of a reader frontend: four general timers, one wake timer,
// the shared control register and the timer interrupt flags
// assumes a register master on clock_i; event inputs come from logic
// on the same clock, the slow oscillator pin is asynchronous
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "reader_timer_regs.vh"

module reader_timer_unit #(
    parameter NUM_GEN = 4,
    parameter WIDTH   = 16
) (
    // clock and reset
    input  wire               clock_i,
    input  wire               rst_b_i,
    // register port
    input  wire [6:0]         addr_i,
    input  wire [7:0]         wdata_i,
    input  wire               wr_i,
    input  wire               rd_i,
    output reg  [7:0]         rdata_o,
    // protocol events for the general timers
    input  wire [NUM_GEN-1:0] start_event_i,
    input  wire [NUM_GEN-1:0] stop_event_i,
    // oscillator and card detection
    input  wire               slow_osc_i,
    input  wire               detect_done_i,
    input  wire               card_found_i,
    // outputs
    output reg                irq_o,
    output reg                standby_o
);

    localparam NUM_ALL = NUM_GEN + 1;
    localparam WAKE    = NUM_GEN;

    // ===========================================================
    // storage
    reg  [7:0]         cfg_ff    [0:NUM_ALL-1];
    reg  [WIDTH-1:0]   reload_ff [0:NUM_ALL-1];
    reg  [NUM_ALL-1:0] flags_ff;
    reg  [6:0]         irq_en_ff;
    reg  [NUM_ALL-1:0] start_req_ff;
    reg  [NUM_ALL-1:0] stop_req_ff;
    reg  [NUM_ALL-1:0] nxt_start_req;
    reg  [NUM_ALL-1:0] nxt_stop_req;
    reg  [NUM_ALL-1:0] nxt_flags;
    reg  [7:0]         nxt_rdata;
    reg  [NUM_ALL-1:0] tick_sel;

    wire [WIDTH-1:0]   count    [0:NUM_ALL-1];
    wire [NUM_ALL-1:0] running;
    wire [NUM_ALL-1:0] underflow;
    wire               fast_tick;
    wire               slow_tick;
    wire               osc_tick;
    wire [2:0]         wr_sel;
    wire [2:0]         rd_sel;
    wire               wr_global;
    // one loop index per process: a shared index read by two
    // combinational blocks would make them retrigger each other
    integer            i;
    integer            j;
    integer            n;

    // ===========================================================
    // address decode, used for both write and read paths
    function [2:0] timer_sel;
        input [6:0] addr;
        reg   [3:0] slot;
        begin
            slot = addr[6:3] - `TIMER_BASE_INDEX;
            if (addr >= `ADDR_TIMER_BASE && slot < NUM_ALL[3:0]) begin
                timer_sel = slot[2:0];
            end else begin
                timer_sel = `TIMER_NONE;
            end
        end
    endfunction

    assign wr_sel    = timer_sel(addr_i);
    assign rd_sel    = wr_sel;
    assign wr_global = wr_i && (addr_i == `ADDR_GLOBAL_CTRL);

    // ===========================================================
    // tick sources
    tick_gen u_tick_gen (
        .clock_i     (clock_i),
        .rst_b_i     (rst_b_i),
        .slow_osc_i  (slow_osc_i),
        .fast_tick_o (fast_tick),
        .slow_tick_o (slow_tick),
        .osc_tick_o  (osc_tick)
    );

    always @* begin
        for (i = 0; i < NUM_GEN; i = i + 1) begin
            case (cfg_ff[i][`CFG_CLK_LSB +: 2])
                `CLKSEL_FAST: tick_sel[i] = fast_tick;
                `CLKSEL_SLOW: tick_sel[i] = slow_tick;
                // wake underflow is a single-cycle pulse
                `CLKSEL_WAKE: tick_sel[i] = underflow[WAKE];
                default:      tick_sel[i] = 1'b0;
            endcase
        end
        tick_sel[WAKE] = osc_tick;
    end

    // ===========================================================
    // counters
    genvar g;
    generate
        for (g = 0; g < NUM_ALL; g = g + 1) begin : gen_timer
            wire start_evt;
            wire stop_evt;
            if (g < NUM_GEN) begin : gen_events
                assign start_evt = start_event_i[g];
                assign stop_evt  = stop_event_i[g];
            end else begin : gen_no_events
                assign start_evt = 1'b0;
                assign stop_evt  = 1'b0;
            end
            timer_channel #(
                .WIDTH (WIDTH)
            ) u_channel (
                .clock_i       (clock_i),
                .rst_b_i       (rst_b_i),
                .start_req_i   (start_req_ff[g]),
                .stop_req_i    (stop_req_ff[g]),
                .wait_start_i  (cfg_ff[g][`CFG_WAIT_START]),
                .stop_on_evt_i (cfg_ff[g][`CFG_STOP_ON_EVT]),
                .auto_reload_i (cfg_ff[g][`CFG_AUTO_RELOAD]),
                .reload_i      (reload_ff[g]),
                .start_evt_i   (start_evt),
                .stop_evt_i    (stop_evt),
                .tick_i        (tick_sel[g]),
                .count_o       (count[g]),
                .running_o     (running[g]),
                .underflow_o   (underflow[g])
            );
        end
    endgenerate

    // ===========================================================
    // start, stop and flag updates
    always @* begin
        nxt_start_req = {NUM_ALL{1'b0}};
        nxt_stop_req  = {NUM_ALL{1'b0}};
        for (j = 0; j < NUM_GEN; j = j + 1) begin
            if (wr_global && wdata_i[NUM_GEN + j]) begin
                nxt_start_req[j] = wdata_i[j];
                nxt_stop_req[j]  = ~wdata_i[j];
            end
        end
        for (j = 0; j < NUM_ALL; j = j + 1) begin
            if (wr_i && wr_sel == j[2:0] && addr_i[2:0] == `OFS_CONFIG
                && wdata_i[`CFG_START]) begin
                nxt_start_req[j] = 1'b1;
            end
        end
        nxt_flags = flags_ff;
        if (wr_i && addr_i == `ADDR_IRQ_STATUS) begin
            if (wdata_i[`IRQ_SET_BIT]) begin
                nxt_flags = flags_ff | wdata_i[NUM_ALL-1:0];
            end else begin
                nxt_flags = flags_ff & ~wdata_i[NUM_ALL-1:0];
            end
        end
        // a hardware set wins over a clear in the same cycle
        nxt_flags = nxt_flags | underflow;
    end

    // ===========================================================
    // register writes
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (n = 0; n < NUM_ALL; n = n + 1) begin
                cfg_ff[n]    <= `RST_CONFIG;
                reload_ff[n] <= `RST_RELOAD;
            end
            flags_ff     <= {NUM_ALL{1'b0}};
            irq_en_ff    <= `RST_IRQ_ENABLE;
            start_req_ff <= {NUM_ALL{1'b0}};
            stop_req_ff  <= {NUM_ALL{1'b0}};
        end else begin
            flags_ff     <= nxt_flags;
            start_req_ff <= nxt_start_req;
            stop_req_ff  <= nxt_stop_req;
            if (wr_i && addr_i == `ADDR_IRQ_ENABLE) begin
                if (wdata_i[`IRQ_SET_BIT]) begin
                    irq_en_ff <= irq_en_ff | wdata_i[6:0];
                end else begin
                    irq_en_ff <= irq_en_ff & ~wdata_i[6:0];
                end
            end
            if (wr_i && wr_sel != `TIMER_NONE) begin
                case (addr_i[2:0])
                    // start bit acts as a strobe and is not stored
                    `OFS_CONFIG: begin
                        cfg_ff[wr_sel] <= wdata_i & ~(8'h01 << `CFG_START);
                    end
                    `OFS_RELOAD_HIGH: begin
                        reload_ff[wr_sel][15:8] <= wdata_i;
                    end
                    `OFS_RELOAD_LOW: begin
                        reload_ff[wr_sel][7:0] <= wdata_i;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ===========================================================
    // wake control and interrupt pin
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            standby_o <= 1'b0;
            irq_o     <= 1'b0;
        end else begin
            if (underflow[WAKE]) begin
                standby_o <= 1'b0;
            end else if (cfg_ff[WAKE][`CFG_AUTO_STANDBY]
                         && (start_req_ff[WAKE]
                             || (detect_done_i && !card_found_i))) begin
                // no card: back to sleep until the next interval
                standby_o <= 1'b1;
            end
            irq_o <= irq_en_ff[`IRQ_PIN_EN_BIT]
                     && |(nxt_flags & irq_en_ff[NUM_ALL-1:0]);
        end
    end

    // ===========================================================
    // register reads, data valid in the cycle after the strobe
    always @* begin
        nxt_rdata = 8'h00;
        if (addr_i == `ADDR_GLOBAL_CTRL) begin
            nxt_rdata[NUM_GEN-1:0] = running[NUM_GEN-1:0];
        end else if (addr_i == `ADDR_IRQ_STATUS) begin
            nxt_rdata[NUM_ALL-1:0] = flags_ff;
        end else if (addr_i == `ADDR_IRQ_ENABLE) begin
            nxt_rdata[6:0] = irq_en_ff;
        end else if (addr_i == `ADDR_STANDBY) begin
            nxt_rdata = {6'h00, running[WAKE], standby_o};
        end else if (rd_sel != `TIMER_NONE) begin
            case (addr_i[2:0])
                `OFS_CONFIG:      nxt_rdata = cfg_ff[rd_sel];
                `OFS_RELOAD_HIGH: nxt_rdata = reload_ff[rd_sel][15:8];
                `OFS_RELOAD_LOW:  nxt_rdata = reload_ff[rd_sel][7:0];
                `OFS_COUNT_HIGH:  nxt_rdata = count[rd_sel][15:8];
                `OFS_COUNT_LOW:   nxt_rdata = count[rd_sel][7:0];
                default:          nxt_rdata = 8'h00;
            endcase
        end
    end

    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            rdata_o <= nxt_rdata;
        end else begin
            rdata_o <= 8'h00;
        end
    end

endmodule // reader_timer_unit

// File: hw/reader_timer_regs.vh
// register offsets, field positions, reset values and tick figures
// of the reader timer unit; included by every design file of the block
`ifndef READER_TIMER_REGS_VH
`define READER_TIMER_REGS_VH

// ===========================================================
// register offsets (7-bit register address)
`define ADDR_GLOBAL_CTRL   7'h00
`define ADDR_IRQ_STATUS    7'h01
`define ADDR_IRQ_ENABLE    7'h02
`define ADDR_STANDBY       7'h03
`define ADDR_TIMER_BASE    7'h10
`define TIMER_BASE_INDEX   4'h2
`define OFS_CONFIG         3'h0
`define OFS_RELOAD_HIGH    3'h1
`define OFS_RELOAD_LOW     3'h2
`define OFS_COUNT_HIGH     3'h3
`define OFS_COUNT_LOW      3'h4
`define TIMER_NONE         3'h7

// ===========================================================
// field positions
`define CFG_CLK_LSB        0
`define CFG_AUTO_RELOAD    2
`define CFG_START          3
`define CFG_WAIT_START     4
`define CFG_STOP_ON_EVT    5
`define CFG_AUTO_STANDBY   7
`define IRQ_SET_BIT        7
`define IRQ_PIN_EN_BIT     6
`define CLKSEL_FAST        2'h0
`define CLKSEL_SLOW        2'h1
`define CLKSEL_WAKE        2'h2

// ===========================================================
// reset values
`define RST_CONFIG         8'h00
`define RST_RELOAD         16'h0000
`define RST_IRQ_ENABLE     7'h00

// ===========================================================
// tick generation: rates in kHz, slow tick is fast tick over 64
`define SYS_CLK_KHZ        25000
`define FAST_TICK_KHZ      13560
`define SLOW_TICK_DIV      64

`endif

// File: hw/tick_gen.v
// tick enables for the timer unit: crystal-derived fast and slow ticks
// by a phase accumulator, and rising edges of the slow internal oscillator
// assumes one system clock; slow_osc_i is asynchronous to it
`timescale 1ns/1ps
`include "reader_timer_regs.vh"

module tick_gen #(
    parameter SYS_KHZ  = `SYS_CLK_KHZ,
    parameter FAST_KHZ = `FAST_TICK_KHZ,
    parameter SLOW_DIV = `SLOW_TICK_DIV
) (
    // clock and reset
    input  wire        clock_i,
    input  wire        rst_b_i,
    // oscillator pin
    input  wire        slow_osc_i,
    // tick enables
    output reg         fast_tick_o,
    output reg         slow_tick_o,
    output reg         osc_tick_o
);

    reg  [15:0] acc_ff;
    reg  [6:0]  div_ff;
    reg         osc_s1_ff;
    reg         osc_s2_ff;
    reg         osc_s3_ff;
    wire [15:0] acc_sum;
    wire        acc_wrap;

    // ===========================================================
    // fractional divider: average rate exact, jitter one clock
    assign acc_sum  = acc_ff + FAST_KHZ[15:0];
    assign acc_wrap = (acc_sum >= SYS_KHZ[15:0]);

    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            acc_ff      <= 16'h0000;
            div_ff      <= 7'h00;
            fast_tick_o <= 1'b0;
            slow_tick_o <= 1'b0;
        end else begin
            acc_ff      <= acc_wrap ? acc_sum - SYS_KHZ[15:0] : acc_sum;
            fast_tick_o <= acc_wrap;
            slow_tick_o <= 1'b0;
            if (acc_wrap) begin
                if (div_ff == SLOW_DIV[6:0] - 7'h01) begin
                    div_ff      <= 7'h00;
                    slow_tick_o <= 1'b1;
                end else begin
                    div_ff <= div_ff + 7'h01;
                end
            end
        end
    end

    // ===========================================================
    // oscillator: two-flop synchroniser, edge seen on later stages
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            osc_s1_ff  <= 1'b0;
            osc_s2_ff  <= 1'b0;
            osc_s3_ff  <= 1'b0;
            osc_tick_o <= 1'b0;
        end else begin
            osc_s1_ff  <= slow_osc_i;
            osc_s2_ff  <= osc_s1_ff;
            osc_s3_ff  <= osc_s2_ff;
            osc_tick_o <= osc_s2_ff & ~osc_s3_ff;
        end
    end

endmodule // tick_gen

// File: hw/timer_channel.v
// one 16-bit down-counter with reload, start and stop events
// assumes tick_i and all requests are one-cycle pulses on clock_i
`timescale 1ns/1ps
`include "reader_timer_regs.vh"

module timer_channel #(
    parameter WIDTH = 16
) (
    // clock and reset
    input  wire             clock_i,
    input  wire             rst_b_i,
    // control
    input  wire             start_req_i,
    input  wire             stop_req_i,
    input  wire             wait_start_i,
    input  wire             stop_on_evt_i,
    input  wire             auto_reload_i,
    input  wire [WIDTH-1:0] reload_i,
    // events and tick
    input  wire             start_evt_i,
    input  wire             stop_evt_i,
    input  wire             tick_i,
    // state
    output reg  [WIDTH-1:0] count_o,
    output wire             running_o,
    output reg              underflow_o
);

    localparam ST_IDLE  = 2'h0;
    localparam ST_ARMED = 2'h1;
    localparam ST_RUN   = 2'h2;

    localparam [WIDTH-1:0] DEC_STEP = {{(WIDTH-1){1'b0}}, 1'b1};

    reg [1:0] state_ff;

    assign running_o = (state_ff == ST_RUN);

    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_ff    <= ST_IDLE;
            count_o     <= {WIDTH{1'b0}};
            underflow_o <= 1'b0;
        end else begin
            underflow_o <= 1'b0;
            if (stop_req_i) begin
                state_ff <= ST_IDLE;
            end else if (start_req_i) begin
                count_o  <= reload_i;
                state_ff <= wait_start_i ? ST_ARMED : ST_RUN;
            end else begin
                case (state_ff)
                    ST_ARMED: begin
                        if (start_evt_i) begin
                            state_ff <= ST_RUN;
                        end
                    end
                    ST_RUN: begin
                        if (stop_on_evt_i && stop_evt_i) begin
                            // value kept for the host to read
                            state_ff <= ST_IDLE;
                        end else if (tick_i) begin
                            if (count_o == {WIDTH{1'b0}}) begin
                                underflow_o <= 1'b1;
                                if (auto_reload_i) begin
                                    count_o <= reload_i;
                                end else begin
                                    state_ff <= ST_IDLE;
                                end
                            end else begin
                                count_o <= count_o - DEC_STEP;
                            end
                        end
                    end
                    default: begin
                        state_ff <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule // timer_channel

// File: tb/reader_timer_unit_asserts.sv
// port checker of the reader timer unit, bound to its top module
// assumes the register map of the shared header
`timescale 1ns/1ps
`include "reader_timer_regs.vh"

// ===========================================================
// checker
module reader_timer_unit_chk #(
    parameter NUM_GEN = 4,
    parameter WIDTH   = 16
) (
    // watched ports
    input wire               clock_i,
    input wire               rst_b_i,
    input wire [6:0]         addr_i,
    input wire [7:0]         wdata_i,
    input wire               wr_i,
    input wire               rd_i,
    input wire [7:0]         rdata_o,
    input wire [NUM_GEN-1:0] start_event_i,
    input wire [NUM_GEN-1:0] stop_event_i,
    input wire               slow_osc_i,
    input wire               detect_done_i,
    input wire               card_found_i,
    input wire               irq_o,
    input wire               standby_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    stat_bits_a: assert property (
        rd_i && addr_i == `ADDR_IRQ_STATUS |=> rdata_o[7:5] == 3'h0)
        else $error("status read shows upper bits");
    ctrl_bits_a: assert property (
        rd_i && addr_i == `ADDR_GLOBAL_CTRL |=> rdata_o[7:4] == 4'h0)
        else $error("control read shows strobe bits");
    en_bits_a: assert property (
        rd_i && addr_i == `ADDR_IRQ_ENABLE |=> !rdata_o[7])
        else $error("enable read shows bit seven");
    unmap_zero_a: assert property (
        rd_i && addr_i > 7'h03 && addr_i < 7'h10 |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    stop_all_a: assert property (
        wr_i && addr_i == `ADDR_GLOBAL_CTRL && wdata_i == 8'hf0 ##1 !wr_i
        ##1 rd_i && addr_i == `ADDR_GLOBAL_CTRL |=> rdata_o[3:0] == 4'h0)
        else $error("timer still running after stop");
    irq_mask_a: assert property (
        wr_i && addr_i == `ADDR_IRQ_ENABLE && wdata_i == 8'h7f ##1 !wr_i
        |=> !irq_o)
        else $error("pin active with enables cleared");
    sby_cause_a: assert property (
        $rose(standby_o) |-> $past(wr_i) || $past(wr_i, 2)
        || $past(wr_i, 3) || $past(detect_done_i)
        || $past(detect_done_i, 2))
        else $error("standby raised without cause");
    sby_read_a: assert property (
        rd_i && addr_i == `ADDR_STANDBY ##1 $stable(standby_o)
        |-> rdata_o[0] == standby_o)
        else $error("standby readback differs from pin");

    cover property ($rose(irq_o));
    cover property ($rose(standby_o));
    cover property (stop_event_i != 4'h0);
endmodule // reader_timer_unit_chk

bind reader_timer_unit reader_timer_unit_chk #(
    .NUM_GEN(NUM_GEN), .WIDTH(WIDTH)
) reader_timer_unit_chk_i (.*);

// File: tb/reader_timer_unit_tb.sv
// self-checking bench of the reader timer unit
// assumes the register map of the shared header and a 25 MHz clock
`timescale 1ns/1ps
`include "reader_timer_regs.vh"

module reader_timer_unit_tb;
    reg         clock_i, rst_b_i, wr_i, rd_i, slow_osc_i;
    reg         detect_done_i, card_found_i;
    reg  [6:0]  addr_i;
    reg  [7:0]  wdata_i, d;
    reg  [3:0]  start_event_i, stop_event_i;
    wire [7:0]  rdata_o;
    wire        irq_o, standby_o;
    integer     bad_count, n_tests, seed, i, k;
    reg  [15:0] r, c;

    reader_timer_unit reader_timer_unit_i (.clock_i(clock_i),
        .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .start_event_i(start_event_i), .stop_event_i(stop_event_i),
        .slow_osc_i(slow_osc_i), .detect_done_i(detect_done_i),
        .card_found_i(card_found_i), .irq_o(irq_o),
        .standby_o(standby_o));

    // ===========================================================
    // clocks and helpers
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end
    // slow oscillator runs free, unrelated in phase to the clock
    initial begin
        slow_osc_i = 1'b0;
        forever #413 slow_osc_i = ~slow_osc_i;
    end

    function [6:0] ta(input [2:0] t, input [2:0] o);
        ta = `ADDR_TIMER_BASE + {t, o};
    endfunction
    // decrements expected over n system clocks on the fast tick
    function [15:0] fast_ticks(input integer n);
        fast_ticks = (n * `FAST_TICK_KHZ) / `SYS_CLK_KHZ;
    endfunction

    task wr(input [6:0] a, input [7:0] v);
    begin
        @(posedge clock_i);
        addr_i  <= a;
        wdata_i <= v;
        wr_i    <= 1'b1;
        @(posedge clock_i);
        wr_i    <= 1'b0;
    end
    endtask
    task rd(input [6:0] a);
    begin
        @(posedge clock_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clock_i);
        rd_i   <= 1'b0;
        #1 d = rdata_o;
    end
    endtask
    task rd16(input [2:0] t);
    begin
        rd(ta(t, `OFS_COUNT_HIGH));
        c[15:8] = d;
        rd(ta(t, `OFS_COUNT_LOW));
        c[7:0] = d;
    end
    endtask
    task chk(input [15:0] got, input [15:0] exp);
    begin
        n_tests = n_tests + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task chk_near(input [15:0] got, input [15:0] exp);
    begin
        n_tests = n_tests + 1;
        if (^got === 1'bx || got > exp + 3 || got + 3 < exp) begin
            bad_count = bad_count + 1;
            $display("ERROR %0t got %0d near %0d", $time, got, exp);
        end
    end
    endtask
    // looks 1 ns after each edge, once the outputs have settled
    task wait_for(input integer n, input want, input sel);
    begin
        #1;
        k = 0;
        while ((sel ? standby_o : irq_o) !== want && k < n) begin
            @(posedge clock_i);
            #1;
            k = k + 1;
        end
    end
    endtask
    task pulse(input [3:0] st, input [3:0] sp, input dn, input cf);
    begin
        @(posedge clock_i);
        start_event_i <= st;
        stop_event_i  <= sp;
        detect_done_i <= dn;
        card_found_i  <= cf;
        @(posedge clock_i);
        start_event_i <= 4'h0;
        stop_event_i  <= 4'h0;
        detect_done_i <= 1'b0;
    end
    endtask
    task conclude;
    begin
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask

    // ===========================================================
    // watchdog: the tests need a few thousand cycles
    initial begin
        #(40 * 20000);
        bad_count = bad_count + 1;
        conclude;
    end

    // ===========================================================
    // main sequence
    initial begin
        {wr_i, rd_i, detect_done_i, card_found_i} = 4'h0;
        {start_event_i, stop_event_i} = 8'h00;
        addr_i = 7'h00;
        wdata_i = 8'h00;
        bad_count = 0;
        n_tests = 0;
        seed = 32'h6e38;
        rst_b_i = 1'b0;
        repeat (5) @(posedge clock_i);
        rst_b_i <= 1'b1;
        // tick source none keeps the count at the loaded value
        for (i = 0; i < 4; i = i + 1) begin
            r = $random(seed);
            wr(ta(i, `OFS_CONFIG), 8'h03);
            wr(ta(i, `OFS_RELOAD_HIGH), r[15:8]);
            wr(ta(i, `OFS_RELOAD_LOW), r[7:0]);
            wr(`ADDR_GLOBAL_CTRL, 8'h11 << i);
            rd16(i);
            chk(c, r);
            rd(`ADDR_GLOBAL_CTRL);
            chk(d, (8'h02 << i) - 8'h01);
        end
        wr(`ADDR_GLOBAL_CTRL, 8'hf0);
        rd(`ADDR_GLOBAL_CTRL);
        chk(d, 8'h00);
        wr(ta(0, `OFS_CONFIG), 8'h0b);
        rd(`ADDR_GLOBAL_CTRL);
        chk(d, 8'h01);
        rd(7'h04 + ($random(seed) & 7));
        chk(d, 8'h00);
        $display("start and stop test done");
        // armed timer waits for its start event
        wr(ta(3, `OFS_CONFIG), 8'h10);
        wr(`ADDR_GLOBAL_CTRL, 8'h88);
        repeat (20) @(posedge clock_i);
        rd(`ADDR_GLOBAL_CTRL);
        chk(d[3], 1'b0);
        rd16(3);
        chk(c, r);
        pulse(4'h8, 4'h0, 1'b0, 1'b0);
        rd(`ADDR_GLOBAL_CTRL);
        chk(d[3], 1'b1);
        wr(`ADDR_GLOBAL_CTRL, 8'hf0);
        $display("wait start test done");
        // stopwatch: stop event freezes the count, no flag
        wr(`ADDR_IRQ_ENABLE, 8'h84);
        wr(ta(2, `OFS_CONFIG), 8'h20);
        wr(ta(2, `OFS_RELOAD_HIGH), 8'h10);
        wr(ta(2, `OFS_RELOAD_LOW), 8'h00);
        wr(`ADDR_GLOBAL_CTRL, 8'h44);
        i = 200 + ($random(seed) & 255);
        repeat (i) @(posedge clock_i);
        pulse(4'h0, 4'h4, 1'b0, 1'b0);
        rd16(2);
        r = c;
        chk_near(16'h1000 - c, fast_ticks(i));
        rd16(2);
        chk(c, r);
        rd(`ADDR_IRQ_STATUS);
        chk(d[2], 1'b0);
        // slow tick: one decrement per 64 fast ticks
        wr(ta(2, `OFS_CONFIG), 8'h21);
        wr(`ADDR_GLOBAL_CTRL, 8'h44);
        i = 1200;
        repeat (i) @(posedge clock_i);
        pulse(4'h0, 4'h4, 1'b0, 1'b0);
        rd16(2);
        chk_near(16'h1000 - c, fast_ticks(i) / `SLOW_TICK_DIV);
        $display("stopwatch test done");
        // periodic trigger, then host set and clear of the flag
        wr(`ADDR_IRQ_ENABLE, 8'hc1);
        wr(ta(0, `OFS_CONFIG), 8'h04);
        wr(ta(0, `OFS_RELOAD_HIGH), 8'h00);
        wr(ta(0, `OFS_RELOAD_LOW), 8'h05);
        wr(`ADDR_GLOBAL_CTRL, 8'h11);
        wait_for(40, 1'b1, 1'b0);
        chk(irq_o, 1'b1);
        wr(`ADDR_IRQ_STATUS, 8'h01);
        wait_for(40, 1'b1, 1'b0);
        chk(irq_o, 1'b1);
        wr(`ADDR_GLOBAL_CTRL, 8'h10);
        wr(`ADDR_IRQ_STATUS, 8'h01);
        rd(`ADDR_IRQ_STATUS);
        chk(d, 8'h00);
        chk(irq_o, 1'b0);
        wr(`ADDR_IRQ_STATUS, 8'h81);
        rd(`ADDR_IRQ_STATUS);
        chk({d[0], irq_o}, 2'b11);
        wr(`ADDR_IRQ_ENABLE, 8'h7f);
        wr(`ADDR_IRQ_STATUS, 8'h7f);
        chk(irq_o, 1'b0);
        // one-shot halts at zero
        wr(ta(1, `OFS_CONFIG), 8'h00);
        wr(ta(1, `OFS_RELOAD_HIGH), 8'h00);
        wr(ta(1, `OFS_RELOAD_LOW), 8'h03);
        wr(`ADDR_GLOBAL_CTRL, 8'h22);
        repeat (30) @(posedge clock_i);
        rd(`ADDR_GLOBAL_CTRL);
        chk(d[1], 1'b0);
        rd16(1);
        chk(c, 16'h0000);
        rd(`ADDR_IRQ_STATUS);
        chk(d[1], 1'b1);
        $display("interrupt test done");
        // wake timer drives timer one and the standby request
        wr(ta(1, `OFS_CONFIG), 8'h02);
        wr(ta(1, `OFS_RELOAD_LOW), 8'h05);
        wr(`ADDR_GLOBAL_CTRL, 8'h22);
        wr(ta(4, `OFS_RELOAD_LOW), 8'h02);
        wr(ta(4, `OFS_CONFIG), 8'h8c);
        wait_for(4, 1'b1, 1'b1);
        chk(standby_o, 1'b1);
        wait_for(200, 1'b0, 1'b1);
        chk(standby_o, 1'b0);
        rd(`ADDR_IRQ_STATUS);
        chk(d[4], 1'b1);
        rd16(1);
        chk(c, 16'h0004);
        pulse(4'h0, 4'h0, 1'b1, 1'b1);
        rd(`ADDR_STANDBY);
        chk(d[0], 1'b0);
        pulse(4'h0, 4'h0, 1'b1, 1'b0);
        rd(`ADDR_STANDBY);
        chk(d[1:0], 2'b11);
        // auto reload: the next interval wakes again and ticks timer one
        wait_for(200, 1'b0, 1'b1);
        chk(standby_o, 1'b0);
        rd16(1);
        chk(c, 16'h0003);
        $display("wake test done");
        conclude;
    end
endmodule // reader_timer_unit_tb
